// >>> rtl/cac_pkg.sv
package cac_pkg;
    // Command header decode
    localparam logic [7:0] INS_AUTH = 8'h88;
    localparam logic [7:0] P1_AUTH = 8'h00;
    localparam int P2_SPEC_BIT = 7;
    localparam int P2_ZERO_HI = 6;
    localparam int P2_ZERO_LO = 3;
    localparam logic [3:0] P2_ZERO_VAL = 4'h0;

    typedef enum logic [2:0] {
        CTX_RSVD = 3'h0,
        CTX_CARD = 3'h1,
        CTX_NET = 3'h2,
        CTX_COMB = 3'h3,
        CTX_CCK = 3'h4,
        CTX_GCK = 3'h5,
        CTX_SCK = 3'h6,
        CTX_MOD = 3'h7
    } cac_ctx_e;

    // Command data lengths per context
    localparam logic [7:0] LEN_CARD = 8'h14;
    localparam logic [7:0] LEN_NET = 8'h0E;
    localparam logic [7:0] LEN_COMB = 8'h00;
    localparam logic [7:0] LEN_CCK = 8'h11;
    localparam logic [7:0] LEN_GCK = 8'h18;
    localparam logic [7:0] LEN_SCK = 8'h1B;
    localparam logic [7:0] LEN_MOD = 8'h02;

    // Command data field layout, bytes counted from 1
    localparam int ARG_BYTES = 27;
    localparam int ARG_W = 8 * ARG_BYTES;
    localparam int BYTE_REC = 1;
    localparam int BYTE_SRC = 2;
    localparam int BYTE_ID_END = 17;
    localparam logic [4:0] LAST_SHF = 5'h1A;

    // Response lengths
    localparam logic [3:0] RLEN_AUTH = 4'h4;
    localparam logic [3:0] RLEN_COMB = 4'hA;

    localparam int KEY_W = 80;
    localparam int BUF_AW = 5;

    // Status words
    localparam logic [15:0] SW_OK = 16'h9000;
    localparam logic [15:0] SW_MANIP = 16'h9860;
    localparam logic [15:0] SW_NETFAIL = 16'h9870;
    localparam logic [15:0] SW_SEC = 16'h6982;
    localparam logic [15:0] SW_COND = 16'h6985;
    localparam logic [15:0] SW_P1P2 = 16'h6A86;
    localparam logic [15:0] SW_LEN = 16'h6700;
    localparam logic [15:0] SW_INS = 16'h6D00;

    // Key file selectors
    localparam logic [1:0] FILE_GCK = 2'h0;
    localparam logic [1:0] FILE_SCK = 2'h1;
    localparam logic [1:0] FILE_MODIFIED_GROUP_KEY = 2'h2;
    localparam logic [1:0] FILE_CCK = 2'h3;
    localparam logic [7:0] REC_DEFAULT = 8'h01;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RECV = 3'b001,
        ST_LOAD = 3'b011,
        ST_RUN = 3'b010,
        ST_DONE = 3'b110
    } cac_state_e;
endpackage

// >>> rtl/cac_cmd_buf.sv
`timescale 1ns/100ps
module cac_cmd_buf (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic [cac_pkg::BUF_AW-1:0] wr_addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [cac_pkg::BUF_AW-1:0] rd_addr_i,
    output logic [7:0] rd_data_o
);
    logic [7:0] mem [0:(1<<cac_pkg::BUF_AW)-1];

    always_ff @(posedge clk_i) begin
        if (ce_i && wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 8'h00;
        end else if (ce_i) begin
            rd_data_o <= mem[rd_addr_i];
        end
    end
endmodule

// >>> rtl/cac_auth_cmd.sv
`timescale 1ns/100ps
// Overview of operation
// RQ1: Refuse unless application selected and user PIN verified.
// RQ2: Command selected by instruction 88 and first parameter 00.
// RQ3: Second parameter: b8 set, b7..b4 zero, b3..b1 context 001..111.
// RQ4: Any other second-parameter coding runs no key operation.
// RQ5: Host sets expected length to 00 or its maximum.
// RQ6: Card auth data: challenge bytes 1-10, seed bytes 11-20.
// RQ7: Card auth keeps key part A; response fetched later.
// RQ8: Card auth response is four bytes.
// RQ9: Network auth data: response bytes 1-4, seed bytes 5-14.
// RQ10: Stored challenge is required and used as card challenge.
// RQ11: Network auth keeps part B, offers expected response, status.
// RQ12: Combine parts into cipher key, sealed when service 20 set.
// RQ13: Missing part is forced to zero for one-way authentication.
// RQ14: Combine response holds cipher key in bytes 1-10.
// RQ15: Common unseal data: sealed key 1-15, identifier 16-17.
// RQ16: Unseal common key, store with identifier, no data returned.
// RQ17: Group unseal: record, identity, sealed key, version bytes.
// RQ18: Store group key and number, hide it, then run modify.
// RQ19: Static unseal: sealed key 1-15, version 16-17, seed 18-27.
// RQ20: Static key number picks record; write only when flag ok.
// RQ21: Modify data: target record byte 1, source record byte 2.
// RQ22: Derive modified key, write target record, on every new key; code chains it only after common and group key unseal, not static.
// RQ23: Manipulation gives 98 60, failed network auth 98 70.
// RQ24: Crypto runs outside via start and done handshake.
// RQ25: Errors return error status and leave stored keys alone.
module cac_auth_cmd (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire logic APP_SELECTED_I,
    input wire logic PIN_VERIFIED_I,
    input wire logic SERVICE20_I,
    input wire logic CMD_START_I,
    input wire logic [7:0] INS_I,
    input wire logic [7:0] P1_I,
    input wire logic [7:0] P2_I,
    input wire logic [7:0] LC_I,
    input wire logic DATA_VALID_I,
    input wire logic [7:0] DATA_I,
    input wire logic CHALLENGE_VALID_I,
    input wire logic [cac_pkg::KEY_W-1:0] CHALLENGE_I,
    input wire logic RESP_RD_I,
    input wire logic CRYPTO_DONE_I,
    input wire logic CRYPTO_OK_I,
    input wire logic [cac_pkg::KEY_W-1:0] CRYPTO_RES_I,
    input wire logic [cac_pkg::KEY_W-1:0] CRYPTO_AUX_I,
    output logic BUSY_O,
    output logic SW_VALID_O,
    output logic [7:0] SW1_O,
    output logic [7:0] SW2_O,
    output logic [3:0] RESP_LEN_O,
    output logic RESP_BYTE_VALID_O,
    output logic [7:0] RESP_BYTE_O,
    output logic CRYPTO_START_O,
    output logic [2:0] CRYPTO_CTX_O,
    output logic CRYPTO_SEAL_O,
    output logic [cac_pkg::ARG_W-1:0] CRYPTO_ARG_O,
    output logic [cac_pkg::KEY_W-1:0] CRYPTO_KEYA_O,
    output logic [cac_pkg::KEY_W-1:0] CRYPTO_KEYB_O,
    output logic KEY_WR_O,
    output logic [1:0] KEY_FILE_O,
    output logic [7:0] KEY_REC_O,
    output logic [15:0] KEY_ID_O,
    output logic [cac_pkg::KEY_W-1:0] KEY_DATA_O
);
    localparam int KW = cac_pkg::KEY_W;
    localparam int AW = cac_pkg::ARG_W;
    localparam int REC_LSB = 8 * (cac_pkg::ARG_BYTES - cac_pkg::BYTE_REC);
    localparam int SRC_LSB = 8 * (cac_pkg::ARG_BYTES - cac_pkg::BYTE_SRC);
    localparam int ID_LSB = 8 * (cac_pkg::ARG_BYTES - cac_pkg::BYTE_ID_END);

    cac_pkg::cac_state_e st_reg, st_next;
    cac_pkg::cac_ctx_e ctx_reg;
    logic err_reg;
    logic [15:0] sw_reg;
    logic [7:0] lc_reg, cnt_reg;
    logic [4:0] rd_idx_reg, shf_reg;
    logic rd_pend_reg;
    logic [AW-1:0] arg_reg;
    logic [7:0] rd_data;
    logic [KW-1:0] key_a_reg, key_b_reg, dck_reg, chal_reg, resp_reg;
    logic a_valid_reg, b_valid_reg, chal_valid_reg;
    logic [7:0] last_grp_reg, last_cck_reg;

    function automatic logic [7:0] exp_len(input logic [2:0] c);
        case (c)
            cac_pkg::CTX_CARD: exp_len = cac_pkg::LEN_CARD;
            cac_pkg::CTX_NET: exp_len = cac_pkg::LEN_NET;
            cac_pkg::CTX_CCK: exp_len = cac_pkg::LEN_CCK;
            cac_pkg::CTX_GCK: exp_len = cac_pkg::LEN_GCK;
            cac_pkg::CTX_SCK: exp_len = cac_pkg::LEN_SCK;
            cac_pkg::CTX_MOD: exp_len = cac_pkg::LEN_MOD;
            default: exp_len = cac_pkg::LEN_COMB;
        endcase
    endfunction

    // Header decode
    wire cmd_take = st_reg == cac_pkg::ST_IDLE && CMD_START_I;
    wire ins_ok = INS_I == cac_pkg::INS_AUTH; // see RQ2
    wire pre_ok = APP_SELECTED_I && PIN_VERIFIED_I; // see RQ1
    wire [2:0] ctx_in = P2_I[2:0];
    wire p2_ok = P2_I[cac_pkg::P2_SPEC_BIT]
        && P2_I[cac_pkg::P2_ZERO_HI:cac_pkg::P2_ZERO_LO] == cac_pkg::P2_ZERO_VAL
        && ctx_in != cac_pkg::CTX_RSVD; // see RQ3
    wire pp_ok = P1_I == cac_pkg::P1_AUTH && p2_ok; // see RQ4
    wire len_ok = LC_I == exp_len(ctx_in); // see RQ6
    // A network auth without a fresh challenge cannot run
    wire chal_ok = ctx_in != cac_pkg::CTX_NET || chal_valid_reg; // see RQ10
    wire [15:0] chk_sw = !ins_ok ? cac_pkg::SW_INS
        : !pre_ok ? cac_pkg::SW_SEC
        : !pp_ok ? cac_pkg::SW_P1P2
        : !len_ok ? cac_pkg::SW_LEN
        : !chal_ok ? cac_pkg::SW_COND : cac_pkg::SW_OK;
    wire chk_err = chk_sw != cac_pkg::SW_OK; // see RQ25

    wire recv_last = DATA_VALID_I && cnt_reg == lc_reg - 8'h01;
    wire load_done = rd_pend_reg && shf_reg == cac_pkg::LAST_SHF;
    wire run_done = st_reg == cac_pkg::ST_RUN && CRYPTO_DONE_I
        && !CRYPTO_START_O; // see RQ24
    wire ctx_is_unseal = ctx_reg == cac_pkg::CTX_CCK
        || ctx_reg == cac_pkg::CTX_GCK;
    wire chain_go = run_done && CRYPTO_OK_I && ctx_is_unseal; // see RQ22
    wire [7:0] f_rec = arg_reg[REC_LSB +: 8]; // see RQ17
    wire [7:0] f_src = arg_reg[SRC_LSB +: 8];
    wire [15:0] f_id = arg_reg[ID_LSB +: 16]; // see RQ15
    wire [7:0] cck_rec = f_id[7:0];
    wire [7:0] in_byte = {3'b000, shf_reg} < lc_reg ? rd_data : 8'h00;
    wire start_run = st_reg == cac_pkg::ST_LOAD && load_done;
    wire resp_take = st_reg == cac_pkg::ST_IDLE && !CMD_START_I
        && RESP_RD_I && RESP_LEN_O != 4'h0; // see RQ7

    always_comb begin
        st_next = st_reg;
        case (st_reg)
            cac_pkg::ST_IDLE: begin
                if (CMD_START_I) begin
                    st_next = LC_I == 8'h00 ? cac_pkg::ST_LOAD
                        : cac_pkg::ST_RECV;
                end
            end
            cac_pkg::ST_RECV: begin
                if (recv_last) begin
                    st_next = cac_pkg::ST_LOAD;
                end
            end
            cac_pkg::ST_LOAD: begin
                if (err_reg) begin
                    st_next = cac_pkg::ST_DONE; // see RQ25
                end else if (load_done) begin
                    st_next = cac_pkg::ST_RUN;
                end
            end
            cac_pkg::ST_RUN: begin
                if (run_done && !chain_go) begin
                    st_next = cac_pkg::ST_DONE;
                end
            end
            default: st_next = cac_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            st_reg <= cac_pkg::ST_IDLE;
            BUSY_O <= 1'b0;
            SW_VALID_O <= 1'b0;
        end else if (CE_I) begin
            st_reg <= st_next;
            BUSY_O <= st_next != cac_pkg::ST_IDLE;
            SW_VALID_O <= st_reg == cac_pkg::ST_DONE;
        end
    end

    // Command header and status word
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ctx_reg <= cac_pkg::CTX_RSVD;
            lc_reg <= 8'h00;
            err_reg <= 1'b0;
            sw_reg <= cac_pkg::SW_OK;
        end else if (CE_I) begin
            if (cmd_take) begin
                ctx_reg <= cac_pkg::cac_ctx_e'(ctx_in);
                lc_reg <= LC_I;
                err_reg <= chk_err;
                sw_reg <= chk_sw;
            end else if (chain_go) begin
                ctx_reg <= cac_pkg::CTX_MOD; // see RQ18
            end else if (run_done && !CRYPTO_OK_I) begin
                sw_reg <= ctx_reg == cac_pkg::CTX_NET ? cac_pkg::SW_NETFAIL
                    : ctx_is_unseal || ctx_reg == cac_pkg::CTX_SCK
                    ? cac_pkg::SW_MANIP : sw_reg; // see RQ23
            end
        end
    end

    always_comb begin
        SW1_O = sw_reg[15:8];
        SW2_O = sw_reg[7:0];
        CRYPTO_CTX_O = ctx_reg;
        CRYPTO_ARG_O = arg_reg;
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            cnt_reg <= 8'h00;
        end else if (CE_I) begin
            if (cmd_take) begin
                cnt_reg <= 8'h00;
            end else if (st_reg == cac_pkg::ST_RECV && DATA_VALID_I) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

    cac_cmd_buf u_buf (
        .clk_i(CLK_I),
        .rst_n_i(RST_N_I),
        .ce_i(CE_I),
        .wr_en_i(st_reg == cac_pkg::ST_RECV && DATA_VALID_I
            && cnt_reg < 8'h20),
        .wr_addr_i(cnt_reg[4:0]),
        .wr_data_i(DATA_I),
        .rd_addr_i(rd_idx_reg),
        .rd_data_o(rd_data)
    );

    // Walk the buffer into a byte-1-first argument, zero padded
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rd_idx_reg <= 5'h00;
            shf_reg <= 5'h00;
            rd_pend_reg <= 1'b0;
            arg_reg <= '0;
        end else if (CE_I) begin
            if (cmd_take) begin
                rd_idx_reg <= 5'h00;
                shf_reg <= 5'h00;
                rd_pend_reg <= 1'b0;
            end else if (st_reg == cac_pkg::ST_LOAD && !err_reg) begin
                rd_idx_reg <= rd_idx_reg + 5'h01;
                rd_pend_reg <= 1'b1;
                if (rd_pend_reg) begin
                    arg_reg <= {arg_reg[AW-9:0], in_byte}; // see RQ9
                    shf_reg <= shf_reg + 5'h01;
                end
            end else if (chain_go) begin
                arg_reg <= ctx_reg == cac_pkg::CTX_GCK
                    ? {f_rec, last_cck_reg, {(AW-16){1'b0}}}
                    : {last_grp_reg, cck_rec, {(AW-16){1'b0}}}; // see RQ21
            end
        end
    end

    // Crypto launch with internal operands
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CRYPTO_START_O <= 1'b0;
            CRYPTO_SEAL_O <= 1'b0;
            CRYPTO_KEYA_O <= '0;
            CRYPTO_KEYB_O <= '0;
        end else if (CE_I) begin
            CRYPTO_START_O <= start_run || chain_go; // see RQ24
            if (start_run) begin
                CRYPTO_SEAL_O <= SERVICE20_I; // see RQ12
                CRYPTO_KEYA_O <= ctx_reg == cac_pkg::CTX_NET ? chal_reg
                    : ctx_reg == cac_pkg::CTX_CCK ? dck_reg
                    : ctx_reg == cac_pkg::CTX_COMB && a_valid_reg
                    ? key_a_reg : '0; // see RQ13
                CRYPTO_KEYB_O <= ctx_reg == cac_pkg::CTX_COMB
                    && b_valid_reg ? key_b_reg : '0; // see RQ13
            end
        end
    end

    // Internally retained keys and challenge
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            key_a_reg <= '0;
            key_b_reg <= '0;
            dck_reg <= '0;
            chal_reg <= '0;
            a_valid_reg <= 1'b0;
            b_valid_reg <= 1'b0;
            chal_valid_reg <= 1'b0;
            last_grp_reg <= cac_pkg::REC_DEFAULT;
            last_cck_reg <= cac_pkg::REC_DEFAULT;
        end else if (CE_I) begin
            if (CHALLENGE_VALID_I) begin
                chal_reg <= CHALLENGE_I; // see RQ10
            end
            // A new challenge beats its own consumption
            if (CHALLENGE_VALID_I) begin
                chal_valid_reg <= 1'b1;
            end else if (start_run && ctx_reg == cac_pkg::CTX_NET) begin
                chal_valid_reg <= 1'b0;
            end
            if (run_done && ctx_reg == cac_pkg::CTX_CARD) begin
                key_a_reg <= CRYPTO_AUX_I; // see RQ7
                a_valid_reg <= 1'b1;
            end
            if (run_done && ctx_reg == cac_pkg::CTX_NET && CRYPTO_OK_I) begin
                key_b_reg <= CRYPTO_AUX_I; // see RQ11
                b_valid_reg <= 1'b1;
            end
            if (run_done && ctx_reg == cac_pkg::CTX_COMB) begin
                dck_reg <= CRYPTO_AUX_I; // see RQ12
            end
            if (chain_go && ctx_reg == cac_pkg::CTX_GCK) begin
                last_grp_reg <= f_rec;
            end
            if (chain_go && ctx_reg == cac_pkg::CTX_CCK) begin
                last_cck_reg <= cck_rec;
            end
        end
    end

    // Key file writes; group keys never reach the response path
    wire wr_go = run_done && (CRYPTO_OK_I && (ctx_is_unseal
        || ctx_reg == cac_pkg::CTX_SCK)
        || ctx_reg == cac_pkg::CTX_MOD); // see RQ20
    wire [1:0] wr_file = ctx_reg == cac_pkg::CTX_CCK ? cac_pkg::FILE_CCK
        : ctx_reg == cac_pkg::CTX_GCK ? cac_pkg::FILE_GCK
        : ctx_reg == cac_pkg::CTX_SCK ? cac_pkg::FILE_SCK
        : cac_pkg::FILE_MODIFIED_GROUP_KEY;
    wire [7:0] wr_rec = ctx_reg == cac_pkg::CTX_CCK ? cck_rec
        : ctx_reg == cac_pkg::CTX_SCK ? CRYPTO_AUX_I[7:0] : f_rec;
    wire [15:0] wr_id = ctx_reg == cac_pkg::CTX_GCK ? CRYPTO_AUX_I[15:0]
        : ctx_reg == cac_pkg::CTX_MOD ? 16'h0000 : f_id; // see RQ19

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            KEY_WR_O <= 1'b0;
            KEY_FILE_O <= cac_pkg::FILE_GCK;
            KEY_REC_O <= 8'h00;
            KEY_ID_O <= 16'h0000;
            KEY_DATA_O <= '0;
        end else if (CE_I) begin
            KEY_WR_O <= wr_go; // see RQ16
            if (wr_go) begin
                KEY_FILE_O <= wr_file; // see RQ18
                KEY_REC_O <= wr_rec; // see RQ20
                KEY_ID_O <= wr_id;
                KEY_DATA_O <= CRYPTO_RES_I; // see RQ22
            end
        end
    end

    // Response held for a later fetch, MSB byte first
    wire resp_load = run_done && (ctx_reg == cac_pkg::CTX_CARD
        || ctx_reg == cac_pkg::CTX_NET || ctx_reg == cac_pkg::CTX_COMB);

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            resp_reg <= '0;
            RESP_LEN_O <= 4'h0;
            RESP_BYTE_VALID_O <= 1'b0;
            RESP_BYTE_O <= 8'h00;
        end else if (CE_I) begin
            RESP_BYTE_VALID_O <= resp_take;
            if (cmd_take) begin
                RESP_LEN_O <= 4'h0;
            end else if (resp_load) begin
                resp_reg <= CRYPTO_RES_I;
                RESP_LEN_O <= ctx_reg == cac_pkg::CTX_COMB
                    ? cac_pkg::RLEN_COMB : cac_pkg::RLEN_AUTH; // see RQ14
            end else if (resp_take) begin
                RESP_BYTE_O <= resp_reg[KW-1 -: 8]; // see RQ8
                resp_reg <= {resp_reg[KW-9:0], 8'h00};
                RESP_LEN_O <= RESP_LEN_O - 4'h1;
            end
        end
    end

    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);

    a_start_needs_pin: assert property (CE_I && cmd_take && !pre_ok // see RQ1
        |=> err_reg) else $error("start accepted without PIN");
    a_ins_decode: assert property (CE_I && cmd_take && !ins_ok // see RQ2
        |=> sw_reg == cac_pkg::SW_INS) else $error("bad INS not refused");
    a_ctx_reserved: assert property (CRYPTO_START_O // see RQ4
        |-> ctx_reg != cac_pkg::CTX_RSVD) else $error("reserved ctx ran");
    a_err_no_run: assert property (CE_I && st_reg == cac_pkg::ST_LOAD // see RQ25
        && err_reg |=> st_reg == cac_pkg::ST_DONE ##1 !CRYPTO_START_O)
        else $error("error case launched crypto");
    a_card_resp_len: assert property (CE_I && run_done // see RQ8
        && ctx_reg == cac_pkg::CTX_CARD |=> RESP_LEN_O == 4'h4)
        else $error("card response length wrong");
    a_net_fail_sw: assert property (CE_I && run_done && !CRYPTO_OK_I // see RQ23
        && ctx_reg == cac_pkg::CTX_NET |=> sw_reg == cac_pkg::SW_NETFAIL)
        else $error("network failure status wrong");
    a_static_no_write: assert property (CE_I && run_done && !CRYPTO_OK_I // see RQ20
        && ctx_reg == cac_pkg::CTX_SCK |=> !KEY_WR_O
        && sw_reg == cac_pkg::SW_MANIP) else $error("static write on manip");
    a_comb_zero_part: assert property (CRYPTO_START_O && !b_valid_reg // see RQ13
        && ctx_reg == cac_pkg::CTX_COMB |-> CRYPTO_KEYB_O == '0)
        else $error("missing part not zero");
    a_group_chain: assert property (CE_I && chain_go // see RQ18
        |=> CRYPTO_START_O && ctx_reg == cac_pkg::CTX_MOD)
        else $error("modify not chained");
    a_sw_pulse: assert property (CE_I && SW_VALID_O // see RQ25
        |=> !SW_VALID_O) else $error("status strobe stuck");
    a_chain_source: assert property (CE_I && chain_go // see RQ21
        && ctx_reg == cac_pkg::CTX_CCK |=> f_src == $past(cck_rec))
        else $error("modify source record wrong");

    c_card_auth: cover property (run_done && ctx_reg == cac_pkg::CTX_CARD);
    c_combine: cover property (resp_load && ctx_reg == cac_pkg::CTX_COMB);
    c_chain: cover property (chain_go);
    c_fetch: cover property (resp_take ##1 RESP_BYTE_VALID_O);
endmodule

// >>> testbench/cac_crypto_model.sv
`timescale 1ns/100ps
module cac_crypto_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic ok_i,
    input wire logic [2:0] lat_i,
    input wire logic [79:0] res_i,
    output logic done_o,
    output logic ok_o,
    output logic [79:0] res_o,
    output logic [79:0] aux_o
);
    logic [2:0] cnt_reg;

    // Done only after a start, after a chosen latency
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= 3'h0;
            done_o <= 1'b0;
        end else begin
            done_o <= (cnt_reg == 3'h1);
            if (start_i)
                cnt_reg <= lat_i;
            else if (cnt_reg != 3'h0)
                cnt_reg <= cnt_reg - 3'h1;
        end
    end

    // Junk outside the done cycle so a stale sample shows up
    assign ok_o = done_o ? ok_i : ~ok_i;
    assign res_o = done_o ? res_i : ~res_i;
    assign aux_o = {res_o[39:0], res_o[79:40]};
endmodule

// >>> testbench/tb.sv
`timescale 1ns/100ps
module tb;
    logic CLK_I = 0, RST_N_I = 0, CE_I = 1, SERVICE20_I = 0;
    logic APP_SELECTED_I = 1, PIN_VERIFIED_I = 1, CHALLENGE_VALID_I = 0;
    logic CMD_START_I = 0, DATA_VALID_I = 0, RESP_RD_I = 0, ok = 1;
    logic [7:0] INS_I = 0, P1_I = 0, P2_I = 0, LC_I = 0, DATA_I = 0;
    logic [79:0] CHALLENGE_I = 0, res = 0, pa = 0, pb = 0;
    logic CRYPTO_DONE_I, CRYPTO_OK_I, BUSY_O, SW_VALID_O, KEY_WR_O;
    logic RESP_BYTE_VALID_O, CRYPTO_START_O, CRYPTO_SEAL_O;
    logic [79:0] CRYPTO_RES_I, CRYPTO_AUX_I, KEY_DATA_O;
    logic [79:0] CRYPTO_KEYA_O, CRYPTO_KEYB_O;
    logic [7:0] SW1_O, SW2_O, RESP_BYTE_O, KEY_REC_O;
    logic [3:0] RESP_LEN_O;
    logic [2:0] CRYPTO_CTX_O, lat = 1, cur = 0;
    logic [1:0] KEY_FILE_O;
    logic [15:0] KEY_ID_O;
    logic [cac_pkg::ARG_W-1:0] CRYPTO_ARG_O;
    logic [7:0] dat [0:31];
    logic [7:0] lens [1:7] = '{8'h14, 8'h0E, 8'h00, 8'h11, 8'h18, 8'h1B, 8'h02};
    int failures = 0, tests_run = 0, wr_cnt = 0, st_cnt = 0, hit = 0;

    cac_auth_cmd u_cac_auth_cmd (.*);
    cac_crypto_model u_cac_crypto_model (.clk_i(CLK_I), .rst_n_i(RST_N_I),
        .start_i(CRYPTO_START_O), .ok_i(ok), .lat_i(lat), .res_i(res),
        .done_o(CRYPTO_DONE_I), .ok_o(CRYPTO_OK_I), .res_o(CRYPTO_RES_I),
        .aux_o(CRYPTO_AUX_I));

    initial forever #5 CLK_I = ~CLK_I;

    task automatic chk(input string nm, input logic [79:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic tick();
        @(posedge CLK_I);
        #1;
    endtask

    task automatic cmd(input logic [7:0] ins, p1, p2, lc,
                       input logic [15:0] exp);
        int n = 0;
        res = 80'({$urandom, $urandom, $urandom});
        lat = 3'($urandom_range(7, 1));
        SERVICE20_I = 1'($urandom);
        tick();
        CMD_START_I = 1;
        // Expected length is implied 00: all response bytes
        {INS_I, P1_I, P2_I, LC_I} = {ins, p1, p2, lc};
        tick();
        CMD_START_I = 0;
        chk("busy", BUSY_O, 1);
        for (int i = 0; i < lc; i++) begin
            DATA_VALID_I = 1;
            dat[i] = 8'($urandom);
            DATA_I = dat[i];
            tick();
        end
        DATA_VALID_I = 0;
        while (SW_VALID_O !== 1'b1 && n < 500) begin
            tick();
            n++;
        end
        if (n == 500)
            failures++;
        chk("status", {SW1_O, SW2_O}, exp);
        chk("idle", BUSY_O, 0);
    endtask

    task automatic run(input int c, input logic [15:0] exp);
        cur = 3'(c);
        if (c == 2) begin
            CHALLENGE_I = ~res;
            CHALLENGE_VALID_I = 1;
            tick();
            CHALLENGE_VALID_I = 0;
        end
        cmd(8'h88, 8'h00, {5'b1_0000, cur}, lens[c], exp);
        if (c == 1)
            pa = {res[39:0], res[79:40]};
        if (c == 2 && ok)
            pb = {res[39:0], res[79:40]};
    endtask

    task automatic fetch(input int n);
        chk("resp_len", RESP_LEN_O, n);
        for (int i = 0; i < n; i++) begin
            RESP_RD_I = 1;
            tick();
            chk("resp_valid", RESP_BYTE_VALID_O, 1);
            chk("resp_byte", RESP_BYTE_O, res[79-8*i -: 8]);
        end
        RESP_RD_I = 0;
        chk("resp_left", RESP_LEN_O, 0);
    endtask

    // Sampled mid-cycle, clear of the edge that launches each pulse
    always @(negedge CLK_I) begin
        if (KEY_WR_O === 1'b1) begin
            wr_cnt++;
            chk("key_data", KEY_DATA_O, res);
            if (KEY_FILE_O === cac_pkg::FILE_SCK) begin
                chk("sck_rec", KEY_REC_O, res[47:40]);
                chk("sck_ver", KEY_ID_O, {dat[15], dat[16]});
            end
            if (KEY_FILE_O === cac_pkg::FILE_CCK)
                chk("common_key_id", KEY_ID_O, {dat[15], dat[16]});
            if (KEY_FILE_O === cac_pkg::FILE_GCK)
                chk("gck_rec", KEY_REC_O, dat[0]);
        end
        if (CRYPTO_START_O === 1'b1) begin
            st_cnt++;
            if (CRYPTO_CTX_O === cur)
                hit++;
            if (cur != 3 && CRYPTO_CTX_O === cur)
                chk("arg1", CRYPTO_ARG_O[215:208], dat[0]);
            if (cur == 2)
                chk("keya", CRYPTO_KEYA_O, CHALLENGE_I);
            if (cur == 3)
                chk("seal", CRYPTO_SEAL_O, SERVICE20_I);
            if (cur == 3)
                chk("parts", {CRYPTO_KEYA_O, CRYPTO_KEYB_O}, {pa, pb});
        end
    end

    // Generous bound: some twenty commands of well under 100 cycles
    initial begin
        #200000;
        failures++;
        summarize();
    end

    initial begin
        void'($urandom(32'hf244_4a9d));
        repeat (2) @(posedge CLK_I);
        #1;
        RST_N_I = 1;
        chk("reset_sw", {SW1_O, SW2_O}, 16'h9000);
        cmd(8'h87, 8'h00, 8'h81, 8'h00, 16'h6D00);
        APP_SELECTED_I = 0;
        cmd(8'h88, 8'h00, 8'h81, 8'h14, 16'h6982);
        APP_SELECTED_I = 1;
        PIN_VERIFIED_I = 0;
        cmd(8'h88, 8'h00, 8'h81, 8'h14, 16'h6982);
        PIN_VERIFIED_I = 1;
        cmd(8'h88, 8'h01, 8'h81, 8'h14, 16'h6A86);
        cmd(8'h88, 8'h00, 8'h01, 8'h14, 16'h6A86);
        cmd(8'h88, 8'h00, 8'h91, 8'h14, 16'h6A86);
        cmd(8'h88, 8'h00, 8'h80, 8'h00, 16'h6A86);
        cmd(8'h88, 8'h00, 8'h81, 8'h13, 16'h6700);
        cmd(8'h88, 8'h00, 8'h82, 8'h0E, 16'h6985);
        chk("err_quiet", {wr_cnt, st_cnt}, 0);
        for (int c = 1; c < 8; c++) begin
            run(c, 16'h9000);
            if (c < 3)
                fetch(4);
            if (c == 3)
                fetch(10);
        end
        chk("ctx_hits", hit, 7);
        chk("writes", wr_cnt, 6);
        ok = 0;
        for (int c = 2; c < 7; c++) begin
            if (c != 3)
                run(c, c == 2 ? 16'h9870 : 16'h9860);
        end
        chk("no_write", wr_cnt, 6);
        ok = 1;
        RST_N_I = 0;
        pb = 0;
        tick();
        RST_N_I = 1;
        run(1, 16'h9000);
        run(3, 16'h9000);
        summarize();
    end
endmodule
